// >>> design/sid_decode.sv
// Field extraction from the four descriptor words
`timescale 1ns/1ns
module sid_decode (
  // Descriptor words
  input  wire logic [31:0] dw0_i,
  input  wire logic [31:0] dw1_i,
  input  wire logic [31:0] dw2_i,
  input  wire logic [31:0] dw3_i,
  // Lower half fields
  output logic             valid_o,
  output logic [14:0]      byte_count_o,
  output logic [10:0]      packet_size_limit_o,
  output logic [3:0]       endpoint_o,
  output logic [6:0]       func_addr_o,
  output logic [1:0]       token_o,
  output logic [1:0]       xfer_type_o,
  output logic             split_o,
  output logic [1:0]       speed_end_o,
  output logic [6:0]       hub_port_o,
  output logic [6:0]       hub_addr_o,
  // Upper half fields
  output logic [4:0]       poll_field_o,
  output logic [1:0]       cerr_o,
  output logic             toggle_o,
  output logic             start_complete_o,
  output logic             active_o,
  // Checks on the decoded fields
  output logic             format_ok_o,
  output logic             size_ok_o
);
  import sid_pkg::*;

  assign valid_o             = dw0_i[VALID_BIT];
  assign byte_count_o        = dw0_i[BCNT_LSB +: 15];
  assign packet_size_limit_o = dw0_i[MPS_LSB +: 11];
  assign endpoint_o = {dw1_i[EPHI_LSB +: 3], dw0_i[EP0_BIT]};
  assign func_addr_o         = dw1_i[FADDR_LSB +: 7];
  assign token_o             = dw1_i[TOKEN_LSB +: 2];
  assign xfer_type_o         = dw1_i[TYPE_LSB +: 2];
  assign split_o             = dw1_i[SPLIT_BIT];
  // Speed code forced to zero outside split transactions
  assign speed_end_o = split_o ? dw1_i[SPD_LSB +: 2] : 2'h0;
  assign hub_port_o          = dw1_i[PORT_LSB +: 7];
  assign hub_addr_o          = dw1_i[HUB_LSB +: 7];
  assign poll_field_o        = dw2_i[POLL_LSB +: 5];
  assign cerr_o              = dw3_i[CERR_LSB +: 2];
  assign toggle_o            = dw3_i[TOGGLE_BIT];
  assign start_complete_o    = dw3_i[SC_BIT];
  assign active_o            = dw3_i[ACTIVE_BIT];

  // Interrupt type, OUT or IN token, known speed code when split
  assign format_ok_o = (xfer_type_o == TYPE_INT) &&
                       ((token_o == TOKEN_OUT) ||
                        (token_o == TOKEN_IN)) &&
                       (!split_o || (speed_end_o == SPD_LOW) ||
                        (speed_end_o == SPD_FULL));
  assign size_ok_o = (byte_count_o <= MAX_BCNT) &&
                     (!split_o ||
                      (packet_size_limit_o <= SPLIT_MPS));
endmodule // sid_decode

// >>> design/sid_pkg.sv
// Constants for the split interrupt descriptor decoder and engine
// Notes on behaviour
// - Split bit 46 picks high-speed or split
// - Type field 45:44 must be interrupt code 11
// - Token code 00 sends OUT, 01 sends IN
// - Function address taken from bits 41:35
// - Endpoint is bits 34:32 above bit 31
// - Packet size 28:18, split targets max 64
// - Byte count 17:3, at most 4 kB
// - Hardware clears valid when done or fatal; a done start split sets SC_BIT and keeps valid instead
// - Polling field 7:3 selects interrupt period
// - Error counter limits retries, decremented per error
// - Period is two to exponent minus one microframes
// - Speed code used only for split transactions
package sid_pkg;
  localparam int DATA_W = 32;
  localparam int ADDR_W = 5;
  // Register byte offsets
  localparam logic [4:0] DW0_OFS  = 5'h00;
  localparam logic [4:0] DW1_OFS  = 5'h04;
  localparam logic [4:0] DW2_OFS  = 5'h08;
  localparam logic [4:0] DW3_OFS  = 5'h0C;
  localparam logic [4:0] STAT_OFS = 5'h10;
  localparam logic [4:0] CTRL_OFS = 5'h14;
  // Field positions within their 32-bit word
  localparam int VALID_BIT   = 0;   // DW0
  localparam int BCNT_LSB    = 3;   // DW0 17:3
  localparam int MPS_LSB     = 18;  // DW0 28:18
  localparam int EP0_BIT     = 31;  // DW0
  localparam int EPHI_LSB    = 0;   // DW1 2:0
  localparam int FADDR_LSB   = 3;   // DW1 9:3
  localparam int TOKEN_LSB   = 10;  // DW1 11:10
  localparam int TYPE_LSB    = 12;  // DW1 13:12
  localparam int SPLIT_BIT   = 14;  // DW1
  localparam int SPD_LSB     = 16;  // DW1 17:16
  localparam int PORT_LSB    = 18;  // DW1 24:18
  localparam int HUB_LSB     = 25;  // DW1 31:25
  localparam int POLL_LSB    = 3;   // DW2 7:3
  localparam int XFER_LSB    = 0;   // DW3 11:0
  localparam int CERR_LSB    = 23;  // DW3 24:23
  localparam int TOGGLE_BIT  = 25;  // DW3
  localparam int SC_BIT      = 27;  // DW3
  localparam int XERR_BIT    = 28;  // DW3
  localparam int HALT_BIT    = 30;  // DW3
  localparam int ACTIVE_BIT  = 31;  // DW3
  // Encodings and limits
  localparam logic [1:0]  TYPE_INT    = 2'h3;
  localparam logic [1:0]  TOKEN_OUT   = 2'h0;
  localparam logic [1:0]  TOKEN_IN    = 2'h1;
  localparam logic [1:0]  SPD_LOW     = 2'h2;
  localparam logic [1:0]  SPD_FULL    = 2'h0;
  localparam logic [10:0] SPLIT_MPS   = 11'h040;
  localparam logic [14:0] MAX_BCNT    = 15'h1000;
  // Microframe timing
  localparam int CLK_MHZ      = 10;
  localparam int MFRAME_NS    = 125000;
  localparam int MFRAME_CYC   = (MFRAME_NS * CLK_MHZ) / 1000;
  localparam int POLL_EXP_MIN = 4;
  // Reset values
  localparam logic [31:0] WORD_RST  = 32'h0000_0000;
  localparam logic        CTRL_RST  = 1'b0;
  // Engine states
  typedef enum logic [2:0] {
    SID_IDLE  = 3'b001,
    SID_ISSUE = 3'b010,
    SID_WAIT  = 3'b100
  } sid_state_t;
endpackage

// >>> design/sid_poll.sv
// Microframe divider and interrupt polling period timer
`timescale 1ns/1ns
module sid_poll #(
  parameter int CNT_W = 16
) (
  // Clock and reset
  input  wire logic       sys_clk_i,
  input  wire logic       arst_n_i,
  // Control
  input  wire logic       run_i,
  input  wire logic [4:0] poll_field_i,
  // Timing pulses
  output logic            mframe_o,
  output logic            due_o
);
  import sid_pkg::*;

  localparam int DIV_W = $clog2(MFRAME_CYC);
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(MFRAME_CYC - 1);

  logic [DIV_W-1:0] div_cnt;
  logic [CNT_W-1:0] mf_cnt;
  logic [CNT_W-1:0] period;
  logic [4:0]       exp_m1;

  // Exponent minus one: 3 for field zero, else 4 plus top set bit
  always_comb begin
    exp_m1 = 5'(POLL_EXP_MIN - 1);
    for (int i = 0; i < 5; i++) begin
      if (poll_field_i[i]) begin
        exp_m1 = 5'(POLL_EXP_MIN + i);
      end
    end
  end
  assign period = CNT_W'(1) << exp_m1;

  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      div_cnt  <= '0;
      mframe_o <= 1'b0;
    end else begin
      mframe_o <= (div_cnt == DIV_LAST);
      div_cnt  <= (div_cnt == DIV_LAST) ? '0 : div_cnt + 1'b1;
    end
  end

  // Count microframe starts while the descriptor is armed
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      mf_cnt <= '0;
      due_o  <= 1'b0;
    end else if (!run_i) begin
      mf_cnt <= '0;
      due_o  <= 1'b0;
    end else begin
      due_o <= 1'b0;
      if (mframe_o) begin
        if (mf_cnt >= period - 1'b1) begin
          mf_cnt <= '0;
          due_o  <= 1'b1;
        end else begin
          mf_cnt <= mf_cnt + 1'b1;
        end
      end
    end
  end

  chk_poll_16ms : assert property (@(posedge sys_clk_i)
    disable iff (!arst_n_i)
    (poll_field_i == 5'h08) |-> (period == CNT_W'(128)))
    else $error("16 ms polling code gives wrong period");

  chk_due_on_mframe : assert property (@(posedge sys_clk_i)
    disable iff (!arst_n_i)
    $rose(due_o) |-> $past(mframe_o))
    else $error("poll due without a microframe start");
endmodule // sid_poll

// >>> design/sid_top.sv
// Split interrupt descriptor store, decoder and transaction engine
`timescale 1ns/1ns
module sid_top (
  // Clock and reset
  input  wire logic                        sys_clk_i,
  input  wire logic                        arst_n_i,
  // Avalon-MM slave
  input  wire logic [sid_pkg::ADDR_W-1:0]  avs_address_i,
  input  wire logic                        avs_read_i,
  input  wire logic                        avs_write_i,
  input  wire logic [sid_pkg::DATA_W-1:0]  avs_writedata_i,
  input  wire logic [3:0]                  avs_byteenable_i,
  output logic      [sid_pkg::DATA_W-1:0]  avs_readdata_o,
  output logic                             avs_waitrequest_o,
  // Transaction request to the bus engine
  output logic                             token_req_o,
  output logic [1:0]                       token_pid_o,
  output logic [6:0]                       func_addr_o,
  output logic [3:0]                       endpoint_o,
  output logic                             split_o,
  output logic                             start_complete_o,
  output logic [1:0]                       speed_end_o,
  output logic [6:0]                       hub_addr_o,
  output logic [6:0]                       hub_port_o,
  output logic                             data_toggle_o,
  output logic [10:0]                      packet_size_limit_o,
  output logic [14:0]                      transfer_byte_count_o,
  // Transaction outcome
  input  wire logic                        xact_done_i,
  input  wire logic                        xact_err_i,
  input  wire logic                        xact_fatal_i,
  input  wire logic [11:0]                 xact_bytes_i,
  // Status
  output logic                             busy_o
);
  import sid_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // Declarations
  logic [31:0] dw [4];
  logic        eng_en;
  logic        flt_fmt;
  logic        flt_size;
  sid_state_t  state;
  sid_state_t  next_state;
  logic        bus_req;
  logic        wr_go;
  logic        rd_go;
  logic [31:0] rd_mux;
  logic        d_valid;
  logic [14:0] d_bcnt;
  logic [10:0] d_mps;
  logic [3:0]  d_ep;
  logic [6:0]  d_faddr;
  logic [1:0]  d_token;
  logic [1:0]  d_type;
  logic        d_split;
  logic [1:0]  d_spd;
  logic [6:0]  d_port;
  logic [6:0]  d_hub;
  logic [4:0]  d_poll;
  logic [1:0]  d_cerr;
  logic        d_tog;
  logic        d_sc;
  logic        d_active;
  logic        d_fmt_ok;
  logic        d_size_ok;
  logic        armed;
  logic        mframe;
  logic        due;
  logic        launch;
  logic        reject;
  logic        hw_retire;
  logic        hw_halt;
  logic        hw_xerr;
  logic        hw_dec;
  logic        hw_bytes;
  logic        hw_sc_set;

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] wd,
                                        input logic [3:0]  be);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        r[b*8 +: 8] = wd[b*8 +: 8];
      end
    end
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Decoder and poll timer
  sid_decode u_decode (
    .dw0_i               (dw[0]),
    .dw1_i               (dw[1]),
    .dw2_i               (dw[2]),
    .dw3_i               (dw[3]),
    .valid_o             (d_valid),
    .byte_count_o        (d_bcnt),
    .packet_size_limit_o (d_mps),
    .endpoint_o          (d_ep),
    .func_addr_o         (d_faddr),
    .token_o             (d_token),
    .xfer_type_o         (d_type),
    .split_o             (d_split),
    .speed_end_o         (d_spd),
    .hub_port_o          (d_port),
    .hub_addr_o          (d_hub),
    .poll_field_o        (d_poll),
    .cerr_o              (d_cerr),
    .toggle_o            (d_tog),
    .start_complete_o    (d_sc),
    .active_o            (d_active),
    .format_ok_o         (d_fmt_ok),
    .size_ok_o           (d_size_ok)
  );

  // Descriptor is live only with both valid and active set
  assign armed = eng_en && d_valid && d_active;

  sid_poll u_poll (
    .sys_clk_i    (sys_clk_i),
    .arst_n_i     (arst_n_i),
    .run_i        (armed),
    .poll_field_i (d_poll),
    .mframe_o     (mframe),
    .due_o        (due)
  );

  ////////////////////////////////////////////////////////////////////////
  // Engine
  // Complete split follows its start split on the next microframe
  assign launch = (state == SID_IDLE) && armed &&
                  ((d_split && d_sc) ? mframe : due);
  assign reject = launch && !(d_fmt_ok && d_size_ok);

  always_comb begin
    hw_retire = 1'b0;
    hw_halt   = 1'b0;
    hw_xerr   = 1'b0;
    hw_dec    = 1'b0;
    hw_bytes  = 1'b0;
    hw_sc_set = 1'b0;
    if (reject) begin
      hw_retire = 1'b1;
      hw_halt   = 1'b1;
    end else if (state == SID_WAIT) begin
      if (xact_fatal_i) begin
        hw_retire = 1'b1;
        hw_halt   = 1'b1;
      end else if (xact_done_i) begin
        hw_bytes = 1'b1;
        if (d_split && !d_sc) begin
          hw_sc_set = 1'b1;
        end else begin
          hw_retire = 1'b1;
        end
      end else if (xact_err_i) begin
        if (d_cerr == 2'h0) begin
          hw_retire = 1'b1;
          hw_halt   = 1'b1;
          hw_xerr   = 1'b1;
        end else begin
          hw_dec = 1'b1;
        end
      end
    end
  end

  always_comb begin
    next_state = state;
    case (state)
      SID_IDLE: begin
        if (launch && !reject) begin
          next_state = SID_ISSUE;
        end
      end
      SID_ISSUE: begin
        next_state = SID_WAIT;
      end
      SID_WAIT: begin
        if (hw_dec) begin
          next_state = SID_ISSUE;
        end else if (xact_fatal_i || xact_done_i || xact_err_i) begin
          next_state = SID_IDLE;
        end
      end
      default: begin
        next_state = SID_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state  <= SID_IDLE;
      busy_o <= 1'b0;
    end else begin
      state  <= next_state;
      busy_o <= (next_state != SID_IDLE);
    end
  end

  // Token outputs captured from the decoded descriptor
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      token_req_o           <= 1'b0;
      token_pid_o           <= TOKEN_OUT;
      func_addr_o           <= '0;
      endpoint_o            <= '0;
      split_o               <= 1'b0;
      start_complete_o      <= 1'b0;
      speed_end_o           <= SPD_FULL;
      hub_addr_o            <= '0;
      hub_port_o            <= '0;
      data_toggle_o         <= 1'b0;
      packet_size_limit_o   <= '0;
      transfer_byte_count_o <= '0;
    end else begin
      token_req_o <= (state == SID_ISSUE);
      if (state == SID_ISSUE) begin
        token_pid_o           <= d_token;
        func_addr_o           <= d_faddr;
        endpoint_o            <= d_ep;
        split_o               <= d_split;
        start_complete_o      <= d_sc;
        speed_end_o           <= d_spd;
        hub_addr_o            <= d_hub;
        hub_port_o            <= d_port;
        data_toggle_o         <= d_tog;
        packet_size_limit_o   <= d_mps;
        transfer_byte_count_o <= d_bcnt;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Avalon-MM slave
  assign bus_req = avs_read_i || avs_write_i;
  assign wr_go   = avs_write_i && !avs_waitrequest_o;
  assign rd_go   = avs_read_i && avs_waitrequest_o;

  always_comb begin
    case (avs_address_i)
      DW0_OFS:  rd_mux = dw[0];
      DW1_OFS:  rd_mux = dw[1];
      DW2_OFS:  rd_mux = dw[2];
      DW3_OFS:  rd_mux = dw[3];
      STAT_OFS: rd_mux = {26'h0, state, flt_size, flt_fmt, busy_o};
      CTRL_OFS: rd_mux = {31'h0, eng_en};
      default:  rd_mux = 32'h0000_0000;
    endcase
  end

  // One wait cycle, then a single answer cycle
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      avs_waitrequest_o <= 1'b1;
      avs_readdata_o    <= '0;
    end else begin
      avs_waitrequest_o <= !(bus_req && avs_waitrequest_o);
      if (rd_go) begin
        avs_readdata_o <= rd_mux;
      end
    end
  end

  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      eng_en <= CTRL_RST;
    end else if (wr_go && (avs_address_i == CTRL_OFS) &&
                 avs_byteenable_i[0]) begin
      eng_en <= avs_writedata_i[0];
    end
  end

  // Sticky faults, write one to clear, a new fault wins
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      flt_fmt  <= 1'b0;
      flt_size <= 1'b0;
    end else begin
      if (wr_go && (avs_address_i == STAT_OFS) && avs_byteenable_i[0]) begin
        flt_fmt  <= flt_fmt && !avs_writedata_i[1];
        flt_size <= flt_size && !avs_writedata_i[2];
      end
      if (reject && !d_fmt_ok) begin
        flt_fmt <= 1'b1;
      end
      if (reject && !d_size_ok) begin
        flt_size <= 1'b1;
      end
    end
  end

  // Descriptor words: bus write first, hardware updates take priority
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      for (int i = 0; i < 4; i++) begin
        dw[i] <= WORD_RST;
      end
    end else begin
      for (int i = 0; i < 4; i++) begin
        if (wr_go && (avs_address_i == 5'(i * 4))) begin
          dw[i] <= merge(dw[i], avs_writedata_i, avs_byteenable_i);
        end
      end
      if (hw_retire) begin
        dw[0][VALID_BIT]  <= 1'b0;
        dw[3][ACTIVE_BIT] <= 1'b0;
        dw[3][SC_BIT]     <= 1'b0;
      end
      if (hw_halt) begin
        dw[3][HALT_BIT] <= 1'b1;
      end
      if (hw_xerr) begin
        dw[3][XERR_BIT] <= 1'b1;
      end
      if (hw_dec) begin
        dw[3][CERR_LSB +: 2] <= d_cerr - 2'h1;
      end
      if (hw_bytes) begin
        dw[3][XFER_LSB +: 12] <= xact_bytes_i;
        dw[3][TOGGLE_BIT]     <= !d_tog;
      end
      if (hw_sc_set) begin
        dw[3][SC_BIT] <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks
  chk_bus_answer : assert property (@(posedge sys_clk_i)
    disable iff (!arst_n_i)
    (bus_req && avs_waitrequest_o) |=> !avs_waitrequest_o)
    else $error("bus request not answered after one cycle");

  chk_issue_type : assert property (@(posedge sys_clk_i)
    disable iff (!arst_n_i)
    (state == SID_ISSUE) |-> (d_type == TYPE_INT))
    else $error("non-interrupt descriptor issued");

  chk_token_addr : assert property (@(posedge sys_clk_i)
    disable iff (!arst_n_i)
    (state == SID_ISSUE) |=> token_req_o &&
      (func_addr_o == $past(dw[1][FADDR_LSB +: 7])))
    else $error("token address not taken from descriptor");

  chk_token_ep : assert property (@(posedge sys_clk_i)
    disable iff (!arst_n_i)
    (state == SID_ISSUE) |=>
      (endpoint_o == {$past(dw[1][2:0]), $past(dw[0][EP0_BIT])}))
    else $error("endpoint number assembled wrongly");

  chk_token_pid : assert property (@(posedge sys_clk_i)
    disable iff (!arst_n_i)
    token_req_o |-> ((token_pid_o == TOKEN_OUT) ||
                     (token_pid_o == TOKEN_IN)))
    else $error("token code is neither OUT nor IN");

  chk_split_size : assert property (@(posedge sys_clk_i)
    disable iff (!arst_n_i)
    (token_req_o && split_o) |-> (packet_size_limit_o <= SPLIT_MPS))
    else $error("split packet size above limit");

  chk_spd_plain : assert property (@(posedge sys_clk_i)
    disable iff (!arst_n_i)
    (token_req_o && !split_o) |-> (speed_end_o == SPD_FULL))
    else $error("speed code set on plain transaction");

  chk_fatal_clear : assert property (@(posedge sys_clk_i)
    disable iff (!arst_n_i)
    ((state == SID_WAIT) && xact_fatal_i) |=>
      (!dw[0][VALID_BIT] && !dw[3][ACTIVE_BIT] && (state == SID_IDLE)))
    else $error("valid not cleared on fatal error");

  chk_cerr_step : assert property (@(posedge sys_clk_i)
    disable iff (!arst_n_i)
    hw_dec |=> (dw[3][CERR_LSB +: 2] == $past(d_cerr) - 2'h1) ##1
      token_req_o)
    else $error("error count not decremented before retry");

  chk_no_retry : assert property (@(posedge sys_clk_i)
    disable iff (!arst_n_i)
    ((state == SID_WAIT) && xact_err_i && !xact_done_i &&
     !xact_fatal_i && (d_cerr == 2'h0)) |=>
      (dw[3][HALT_BIT] && !dw[0][VALID_BIT]) [*2])
    else $error("retry taken with zero error count");
endmodule // sid_top

// >>> dv/sid_fn_model.sv
// Far-side model that answers each transaction request once
`timescale 1ns/1ns
module sid_fn_model (
  // Clock, reset and request
  input  wire logic        sys_clk_i,
  input  wire logic        arst_n_i,
  input  wire logic        req_i,
  input  wire logic [1:0]  mode_i,
  input  wire logic [3:0]  gap_i,
  input  wire logic [11:0] bytes_i,
  // Outcome
  output logic             done_o,
  output logic             err_o,
  output logic             fatal_o,
  output logic [11:0]      bytes_o
);
  logic [4:0] cnt;
  logic [1:0] mode_r;
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cnt    <= 5'h00;
      mode_r <= 2'h3;
    end else if (req_i) begin
      cnt    <= {1'b0, gap_i} + 5'h01;
      mode_r <= mode_i;
    end else if (cnt != 5'h00) begin
      cnt <= cnt - 5'h01;
    end
  end
  assign done_o  = (cnt == 5'h01) && (mode_r == 2'h0);
  assign err_o   = (cnt == 5'h01) && (mode_r == 2'h1);
  assign fatal_o = (cnt == 5'h01) && (mode_r == 2'h2);
  // Byte count is meaningless outside the answer cycle
  assign bytes_o = done_o ? bytes_i : ~bytes_i;
endmodule // sid_fn_model

// >>> dv/tb_top.sv
// Self-checking bench for the split interrupt descriptor engine
`timescale 1ns/1ns
module tb_top;
  import sid_pkg::*;
  logic        clk, rst_n, rd, wr, wq, tq, spl, sc, bsy, dn, er, ft, tg;
  logic [4:0]  adr;
  logic [31:0] wd, rdo, q, d0, d1;
  logic [1:0]  mode, pid, spe;
  logic [3:0]  gap, ep;
  logic [6:0]  fa, ha, hp;
  logic [10:0] mps;
  logic [14:0] bc;
  logic [11:0] nb, bo;
  int          n_mismatch, num_checks, seed, ntok;
  sid_top i_sid_top (.sys_clk_i(clk), .arst_n_i(rst_n),
    .avs_address_i(adr), .avs_read_i(rd), .avs_write_i(wr),
    .avs_writedata_i(wd), .avs_byteenable_i(4'hF),
    .avs_readdata_o(rdo), .avs_waitrequest_o(wq), .token_req_o(tq),
    .token_pid_o(pid), .func_addr_o(fa), .endpoint_o(ep), .split_o(spl),
    .start_complete_o(sc), .speed_end_o(spe),
    .hub_addr_o(ha), .hub_port_o(hp),
    .data_toggle_o(tg), .packet_size_limit_o(mps), .transfer_byte_count_o(bc),
    .xact_done_i(dn), .xact_err_i(er), .xact_fatal_i(ft),
    .xact_bytes_i(bo), .busy_o(bsy));
  sid_fn_model i_sid_fn_model (.sys_clk_i(clk), .arst_n_i(rst_n),
    .req_i(tq), .mode_i(mode), .gap_i(gap), .bytes_i(nb), .done_o(dn),
    .err_o(er), .fatal_o(ft), .bytes_o(bo));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  always @(posedge clk) if (tq === 1'b1) ntok++;
  task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    num_checks++;
    if (s !== e) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, e, s);
    end
  endtask
  task bus(input logic w, input logic [4:0] a, input logic [31:0] v);
    int k;
    @(posedge clk);
    rd <= !w; wr <= w; adr <= a; wd <= v;
    k = 0;
    do begin @(posedge clk); k++; end while (wq !== 1'b0 && k < 50);
    if (k >= 50) n_mismatch++;
    q = rdo;
    rd <= 1'b0; wr <= 1'b0;
  endtask
  task launch(input logic s, input logic [1:0] c, input logic [1:0] tp);
    d0 = {1'($random(seed)), 2'h0,
          11'(11'h001 + ($random(seed) & 11'h03F)),
          15'(15'h1000 - ($random(seed) & 15'h0FFF)), 3'h1};
    d1 = {14'($random(seed)), SPD_LOW, 1'b0, s, tp,
          s ? TOKEN_IN : TOKEN_OUT, 10'($random(seed))};
    bus(1'b1, DW0_OFS, d0);
    bus(1'b1, DW1_OFS, d1);
    bus(1'b1, DW2_OFS, 32'h0000_0000);
    bus(1'b1, DW3_OFS, {1'b1, 6'h00, c, 23'h0});
    bus(1'b1, CTRL_OFS, 32'h0000_0001);
  endtask
  task wtok(input logic [1:0] m, input logic sce);
    int k;
    mode <= m;
    k = 0;
    do begin @(posedge clk); k++; end while (tq !== 1'b1 && k < 12000);
    chk("token", tq, 1'b1);
    chk("pid", pid, d1[11:10]);
    chk("addr", fa, d1[9:3]);
    chk("ep", ep, {d1[2:0], d0[31]});
    chk("split", spl, d1[14]);
    chk("speed", spe, d1[14] ? d1[17:16] : 2'h0);
    chk("hub", ha, d1[31:25]);
    chk("port", hp, d1[24:18]);
    chk("toggle", tg, sce);
    chk("mps", mps, d0[28:18]);
    chk("bcnt", bc, d0[17:3]);
    chk("sc", sc, sce);
  endtask
  task final_report;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    seed = 32'h8524;
    rst_n = 1'b0; rd = 1'b0; wr = 1'b0; adr = 5'h00; wd = 32'h0;
    mode = 2'h3; gap = 4'h0; nb = 12'h000;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    chk("waitreq", wq, 1'b1);
    bus(1'b0, 5'h18, 32'h0);
    chk("unmapped", q, 32'h0);
    bus(1'b1, DW2_OFS, 32'h0000_0040);
    bus(1'b0, DW2_OFS, 32'h0);
    chk("poll field", q[7:3], 5'h08);
    gap <= 4'($random(seed));
    nb <= 12'($random(seed)) & 12'h03F;
    launch(1'b1, 2'h1, TYPE_INT);
    wtok(2'h1, 1'b0);
    wtok(2'h0, 1'b0);
    wtok(2'h0, 1'b1);
    repeat (8) @(posedge clk);
    bus(1'b0, DW0_OFS, 32'h0);
    chk("valid", q[0], 1'b0);
    bus(1'b0, DW3_OFS, 32'h0);
    chk("active", q[31], 1'b0);
    chk("cerr", q[24:23], 2'h0);
    chk("bytes", q[11:0], nb);
    $display("split run done");
    launch(1'b0, 2'h0, TYPE_INT);
    wtok(2'h2, 1'b0);
    repeat (8) @(posedge clk);
    bus(1'b0, DW0_OFS, 32'h0);
    chk("valid fatal", q[0], 1'b0);
    chk("busy", bsy, 1'b0);
    $display("fatal run done");
    ntok = 0;
    launch(1'b0, 2'h0, TYPE_INT);
    wtok(2'h1, 1'b0);
    repeat (8) @(posedge clk);
    chk("one try", ntok, 1);
    bus(1'b0, DW3_OFS, 32'h0);
    chk("halt", q[30], 1'b1);
    chk("xerr", q[28], 1'b1);
    chk("active err", q[31], 1'b0);
    $display("no retry run done");
    ntok = 0;
    launch(1'b0, 2'h0, 2'h2);
    repeat (11000) @(posedge clk);
    chk("no token", ntok, 0);
    bus(1'b0, STAT_OFS, 32'h0);
    chk("fault", q[1], 1'b1);
    $display("format run done");
    final_report;
  end
  initial begin
    repeat (60000) @(posedge clk);
    n_mismatch++;
    final_report;
  end
endmodule // tb_top
